// *** rtl/scr_pkg.sv ***
// Purpose: Shared constants and types for the system control register bank
// Assumes: 10 MHz host bus clock, AXI4-Lite register access
// Notes:   Byte addresses are 8 bits; upper address bits are ignored
package scr_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 100;

    // Register byte addresses
    localparam logic [7:0] ADDR_SYSCTL = 8'h80;
    localparam logic [7:0] ADDR_ROUTE = 8'h8c;

    // System control field positions
    localparam int BIT_STREAM = 11;
    localparam int BIT_UP = 10;
    localparam int BIT_DN = 9;
    localparam int BIT_PROBE = 8;
    localparam int BIT_GATE = 6;
    localparam int BIT_LOCK = 5;
    localparam int BIT_PAR = 4;
    localparam int BIT_CDMA = 3;
    localparam int BIT_KEEP = 1;
    localparam int BIT_SHARE = 0;

    // Writable masks and reset values
    localparam logic [31:0] SYSCTL_WR_MASK = 32'h0000_007b;
    localparam logic [31:0] SYSCTL_RESET = 32'h0000_0020;
    localparam logic [31:0] ROUTE_WR_MASK = 32'h0fff_ffff;
    localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;

    // Routing fields and codes
    localparam int T6_LSB = 24;
    localparam int T5_LSB = 20;
    localparam logic [3:0] T6_HIZ = 4'h0;
    localparam logic [3:0] T6_CLKRUN = 4'h1;
    localparam logic [3:0] T5_CDMA = 4'h2;

    // Power switch stream and settling times
    localparam int SW_BITS = 8;
    localparam int SETTLE_UP_NS = 50000;
    localparam int SETTLE_DN_NS = 20000;
    localparam int SETTLE_UP_CYC =
        (SETTLE_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_DN_CYC =
        (SETTLE_DN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Serial EEPROM read timing
    localparam int EE_BITS = 32;
    localparam int EE_HALF_NS = 5000;
    localparam int EE_HALF_CYC =
        (EE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        PW_IDLE,
        PW_STREAM,
        PW_LATCH,
        PW_UP,
        PW_DN
    } scr_pwr_e;

    typedef enum logic [1:0] {
        EE_START,
        EE_LOW,
        EE_HIGH,
        EE_DONE
    } scr_ee_e;

    // Register write from the bus slave
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } scr_wr_s;

    function automatic logic scr_addr_ok(input logic [7:0] a);
        return (a == ADDR_SYSCTL) || (a == ADDR_ROUTE);
    endfunction

    function automatic logic [31:0] scr_merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] strb,
        input logic [31:0] mask);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return (res & mask) | (old_v & ~mask);
    endfunction

endpackage

// *** rtl/scr_axil.sv ***
// Purpose: AXI4-Lite slave front end for the register bank
// Assumes: One write and one read outstanding at most
// Notes:   Unmapped addresses answer SLVERR, reads of them give zero
`timescale 1ns/10ps
`default_nettype none
module scr_axil
    import scr_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // Write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // Read address and data
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Register side
    output logic o_wr_go,
    output scr_wr_s o_wr,
    input wire logic [31:0] i_rd_data
);

    typedef struct packed {
        logic aw_v;
        logic [7:0] aw_a;
        logic w_v;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } scr_ax_s;

    scr_ax_s q_r;
    scr_ax_s q_nxt;
    logic ok;

    // Address and data stall while a response is pending
    assign o_awready = !q_r.aw_v && !q_r.bvalid;
    assign o_wready = !q_r.w_v && !q_r.bvalid;
    assign o_arready = !q_r.rvalid;
    assign ok = scr_addr_ok(q_r.aw_a);
    // Register update lands on the same edge that raises bvalid
    assign o_wr_go = q_r.aw_v && q_r.w_v && ok;
    assign o_wr = '{addr: q_r.aw_a, data: q_r.w_d, strb: q_r.w_s};

    always_comb
    begin
        q_nxt = q_r;
        if (i_awvalid && o_awready)
        begin
            q_nxt.aw_v = 1'b1;
            q_nxt.aw_a = i_awaddr;
        end
        if (i_wvalid && o_wready)
        begin
            q_nxt.w_v = 1'b1;
            q_nxt.w_d = i_wdata;
            q_nxt.w_s = i_wstrb;
        end
        if (q_r.aw_v && q_r.w_v)
        begin
            q_nxt.aw_v = 1'b0;
            q_nxt.w_v = 1'b0;
            q_nxt.bvalid = 1'b1;
            q_nxt.bresp = ok ? 2'h0 : 2'h2;
        end
        if (q_r.bvalid && i_bready)
        begin
            q_nxt.bvalid = 1'b0;
        end
        if (q_r.rvalid && i_rready)
        begin
            q_nxt.rvalid = 1'b0;
        end
        if (i_arvalid && o_arready)
        begin
            q_nxt.rvalid = 1'b1;
            q_nxt.rresp = scr_addr_ok(i_araddr) ? 2'h0 : 2'h2;
            q_nxt.rdata = scr_addr_ok(i_araddr) ? i_rd_data : 32'h0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            q_r <= '0;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    assign o_bvalid = q_r.bvalid;
    assign o_bresp = q_r.bresp;
    assign o_rvalid = q_r.rvalid;
    assign o_rdata = q_r.rdata;
    assign o_rresp = q_r.rresp;

endmodule // scr_axil
`default_nettype wire

// *** rtl/scr_eeload.sv ***
// Purpose: Reads default routing value from a serial EEPROM after reset
// Assumes: EEPROM shifts out its word MSB first on rising serial clock
// Notes:   Runs once; absent EEPROM leaves the reset value in place
`timescale 1ns/10ps
`default_nettype none
module scr_eeload
    import scr_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // EEPROM pins
    input wire logic i_ee_present,
    input wire logic i_ee_data,
    output logic o_ee_clk,
    output logic o_ee_cs,
    // Loaded word
    output logic o_load_valid,
    output logic [31:0] o_load_data,
    output logic o_busy
);

    typedef struct packed {
        scr_ee_e st;
        logic [15:0] div;
        logic [5:0] bitn;
        logic [31:0] sh;
        logic clk;
        logic cs;
        logic load_v;
    } scr_ee_s;

    localparam logic [15:0] HALF_LAST = 16'(EE_HALF_CYC - 1);
    localparam logic [5:0] BIT_LAST = 6'(EE_BITS - 1);

    scr_ee_s q_r;
    scr_ee_s q_nxt;

    always_comb
    begin
        q_nxt = q_r;
        q_nxt.load_v = 1'b0;
        case (q_r.st)
            // Presence is sampled after reset release, never under reset
            EE_START:
            begin
                q_nxt.div = '0;
                q_nxt.bitn = '0;
                if (i_ee_present)
                begin
                    q_nxt.cs = 1'b1;
                    q_nxt.st = EE_LOW;
                end
                else
                begin
                    q_nxt.st = EE_DONE;
                end
            end
            EE_LOW:
            begin
                q_nxt.div = q_r.div + 16'h1;
                if (q_r.div == HALF_LAST)
                begin
                    q_nxt.div = '0;
                    q_nxt.clk = 1'b1;
                    q_nxt.st = EE_HIGH;
                end
            end
            EE_HIGH:
            begin
                q_nxt.div = q_r.div + 16'h1;
                if (q_r.div == HALF_LAST)
                begin
                    q_nxt.div = '0;
                    q_nxt.clk = 1'b0;
                    q_nxt.sh = {q_r.sh[30:0], i_ee_data};
                    q_nxt.bitn = q_r.bitn + 6'h1;
                    q_nxt.st = EE_LOW;
                    if (q_r.bitn == BIT_LAST)
                    begin
                        q_nxt.cs = 1'b0;
                        q_nxt.load_v = 1'b1;
                        q_nxt.st = EE_DONE;
                    end
                end
            end
            EE_DONE:
            begin
                q_nxt.clk = 1'b0;
            end
            default:
            begin
                q_nxt.st = EE_DONE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            q_r <= '0;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    assign o_ee_clk = q_r.clk;
    assign o_ee_cs = q_r.cs;
    assign o_load_valid = q_r.load_v;
    assign o_load_data = q_r.sh;
    assign o_busy = (q_r.st != EE_DONE);

endmodule // scr_eeload
`default_nettype wire

// *** rtl/scr_top.sv ***
// Purpose: System control low bits and multifunction routing registers
// Assumes: All inputs synchronous to i_clk; AXI4-Lite master on the bus
// Notes:   Terminal 6 is the only routed pin driven here
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Stream busy flag while switch stream runs
// - Power-up flag until up settling expires
// - Power-down flag until down settling expires
// - Probe busy flag during card interrogation
// - Bits 7 and 2 read zero
// - Gate state machine clock on idle card
// - Bit 5 locks identity registers, resets set
// - Bit 4 forwards card parity to system error
// - Central DMA needs bit 3 and routing
// - Bit 1 blocks both clock stops
// - Shared pin carries both, ring wins
// - Share select set passes only wake event
// - Routing resets zero, bits 31-28 zero
// - Terminal 6 code selects its function
// - All terminals start as inputs
// - Routing default loadable from serial EEPROM
module scr_top
    import scr_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // AXI4-Lite slave
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Power switch request and serial stream
    input wire logic i_pwr_req,
    input wire logic i_pwr_up,
    input wire logic [7:0] i_pwr_code,
    output logic o_sw_clk,
    output logic o_sw_data,
    output logic o_sw_latch,
    // Card interrogation
    input wire logic i_probe_start,
    input wire logic i_probe_done,
    // Card clock gating
    input wire logic i_card_present,
    input wire logic i_card_idle,
    input wire logic i_card_clk_stopped,
    output logic o_cb_sm_clk_en,
    // Identity register lock
    output logic o_id_regs_write_lock,
    // Parity error reporting
    input wire logic i_card_parity_err,
    output logic o_syserr,
    // Centralized DMA
    output logic o_central_dma_en,
    // Clock-run control
    input wire logic i_host_clk_stop_req,
    input wire logic i_card_clk_stop_req,
    output logic o_host_clk_stop_ok,
    output logic o_card_clk_stop_ok,
    // Shared wake terminal
    input wire logic i_ring_ind,
    input wire logic i_ring_en,
    input wire logic i_pme,
    input wire logic i_pme_en,
    output logic o_wake_out,
    // Multifunction terminal 6 and other fields
    input wire logic [15:0] i_isa_irq,
    input wire logic i_clkrun_drive,
    output logic o_mft6_out,
    output logic o_mft6_oe,
    output logic [23:0] o_route_low,
    // Serial EEPROM
    input wire logic i_ee_present,
    input wire logic i_ee_data,
    output logic o_ee_clk,
    output logic o_ee_cs
);

    typedef struct packed {
        scr_pwr_e pw;
        logic [15:0] cnt;
        logic [7:0] shift;
        logic [31:0] ctl;
        logic [31:0] route;
        logic probe;
        logic sw_clk;
        logic sw_data;
        logic sw_latch;
        logic cb_clk_en;
        logic syserr;
        logic cdma;
        logic host_ok;
        logic card_ok;
        logic wake;
        logic mft6_out;
        logic mft6_oe;
        logic [15:0] settle_len;
    } scr_main_s;

    localparam logic [15:0] STREAM_LAST = 16'(2 * SW_BITS - 1);
    localparam logic [15:0] UP_LAST = 16'(SETTLE_UP_CYC - 1);
    localparam logic [15:0] DN_LAST = 16'(SETTLE_DN_CYC - 1);

    scr_main_s q_r;
    scr_main_s q_nxt;
    scr_wr_s wr;
    logic wr_go;
    logic ee_load;
    logic [31:0] ee_data;
    logic stat_stream;
    logic stat_up;
    logic stat_dn;
    logic [31:0] rd_sys;
    logic [31:0] rd_route;
    logic [31:0] rd_data;
    logic [3:0] t6_code;

    scr_axil u_axil (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_awvalid(i_awvalid),
        .o_awready(o_awready),
        .i_awaddr(i_awaddr),
        .i_wvalid(i_wvalid),
        .o_wready(o_wready),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .o_bvalid(o_bvalid),
        .i_bready(i_bready),
        .o_bresp(o_bresp),
        .i_arvalid(i_arvalid),
        .o_arready(o_arready),
        .i_araddr(i_araddr),
        .o_rvalid(o_rvalid),
        .i_rready(i_rready),
        .o_rdata(o_rdata),
        .o_rresp(o_rresp),
        .o_wr_go(wr_go),
        .o_wr(wr),
        .i_rd_data(rd_data)
    );

    scr_eeload u_ee (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_ee_present(i_ee_present),
        .i_ee_data(i_ee_data),
        .o_ee_clk(o_ee_clk),
        .o_ee_cs(o_ee_cs),
        .o_load_valid(ee_load),
        .o_load_data(ee_data),
        .o_busy()
    );

    // Status flags follow the sequencer state
    assign stat_stream = (q_r.pw == PW_STREAM) || (q_r.pw == PW_LATCH);
    assign stat_up = (q_r.pw == PW_UP);
    assign stat_dn = (q_r.pw == PW_DN);
    assign t6_code = q_r.route[T6_LSB +: 4];

    // Reserved bits come back zero through the masks
    always_comb
    begin
        rd_sys = q_r.ctl & SYSCTL_WR_MASK;
        rd_sys[BIT_STREAM] = stat_stream;
        rd_sys[BIT_UP] = stat_up;
        rd_sys[BIT_DN] = stat_dn;
        rd_sys[BIT_PROBE] = q_r.probe;
        rd_route = q_r.route & ROUTE_WR_MASK;
        rd_data = (i_araddr == ADDR_SYSCTL) ? rd_sys : rd_route;
    end

    always_comb
    begin
        q_nxt = q_r;
        // Register writes keep read-only bits through the mask
        if (wr_go && wr.addr == ADDR_SYSCTL)
        begin
            q_nxt.ctl = scr_merge(q_r.ctl, wr.data, wr.strb,
                SYSCTL_WR_MASK);
        end
        if (wr_go && wr.addr == ADDR_ROUTE)
        begin
            q_nxt.route = scr_merge(q_r.route, wr.data, wr.strb,
                ROUTE_WR_MASK);
        end
        // EEPROM default wins over a host write in the same cycle
        if (ee_load)
        begin
            q_nxt.route = ee_data & ROUTE_WR_MASK;
        end

        // Interrogation flag: start beats done if both arrive
        if (i_probe_done)
        begin
            q_nxt.probe = 1'b0;
        end
        if (i_probe_start)
        begin
            q_nxt.probe = 1'b1;
        end

        // Power sequencer; requests while busy are dropped
        q_nxt.sw_latch = 1'b0;
        case (q_r.pw)
            PW_IDLE:
            begin
                q_nxt.sw_clk = 1'b0;
                if (i_pwr_req)
                begin
                    q_nxt.pw = PW_STREAM;
                    q_nxt.cnt = '0;
                    q_nxt.shift = i_pwr_code;
                    q_nxt.sw_data = i_pwr_code[SW_BITS-1];
                end
            end
            PW_STREAM:
            begin
                q_nxt.cnt = q_r.cnt + 16'h1;
                q_nxt.sw_clk = !q_r.cnt[0];
                if (q_r.cnt[0])
                begin
                    q_nxt.shift = {q_r.shift[6:0], 1'b0};
                    q_nxt.sw_data = q_r.shift[6];
                end
                if (q_r.cnt == STREAM_LAST)
                begin
                    q_nxt.pw = PW_LATCH;
                    q_nxt.sw_clk = 1'b0;
                    q_nxt.sw_latch = 1'b1;
                end
            end
            PW_LATCH:
            begin
                q_nxt.cnt = '0;
                q_nxt.pw = i_pwr_up ? PW_UP : PW_DN;
            end
            PW_UP:
            begin
                q_nxt.cnt = q_r.cnt + 16'h1;
                if (q_r.cnt == UP_LAST)
                begin
                    q_nxt.pw = PW_IDLE;
                end
            end
            PW_DN:
            begin
                q_nxt.cnt = q_r.cnt + 16'h1;
                if (q_r.cnt == DN_LAST)
                begin
                    q_nxt.pw = PW_IDLE;
                end
            end
            default:
            begin
                q_nxt.pw = PW_IDLE;
            end
        endcase

        q_nxt.settle_len = stat_up ? q_r.settle_len + 16'h1 : 16'h0;
        // Clock gating only for an idle card with its clock stopped
        q_nxt.cb_clk_en = !(q_r.ctl[BIT_GATE] && i_card_present &&
            i_card_idle && i_card_clk_stopped);
        q_nxt.syserr = i_card_parity_err && q_r.ctl[BIT_PAR];
        q_nxt.cdma = q_r.ctl[BIT_CDMA] &&
            (q_r.route[T5_LSB +: 4] == T5_CDMA);
        q_nxt.host_ok = i_host_clk_stop_req && !q_r.ctl[BIT_KEEP];
        q_nxt.card_ok = i_card_clk_stop_req && !q_r.ctl[BIT_KEEP];

        // Shared wake terminal
        if (q_r.ctl[BIT_SHARE])
        begin
            q_nxt.wake = i_pme_en && i_pme;
        end
        else if (i_ring_en)
        begin
            q_nxt.wake = i_ring_ind;
        end
        else
        begin
            q_nxt.wake = i_pme_en && i_pme;
        end

        // Terminal 6; clock-run is open drain, pulled low only
        case (t6_code)
            T6_HIZ:
            begin
                q_nxt.mft6_out = 1'b0;
                q_nxt.mft6_oe = 1'b0;
            end
            T6_CLKRUN:
            begin
                q_nxt.mft6_out = 1'b0;
                q_nxt.mft6_oe = i_clkrun_drive;
            end
            default:
            begin
                q_nxt.mft6_out = i_isa_irq[t6_code];
                q_nxt.mft6_oe = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            q_r <= '0;
            q_r.ctl <= SYSCTL_RESET;
            q_r.route <= ROUTE_RESET;
            q_r.cb_clk_en <= 1'b1;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    assign o_sw_clk = q_r.sw_clk;
    assign o_sw_data = q_r.sw_data;
    assign o_sw_latch = q_r.sw_latch;
    assign o_cb_sm_clk_en = q_r.cb_clk_en;
    assign o_id_regs_write_lock = q_r.ctl[BIT_LOCK];
    assign o_syserr = q_r.syserr;
    assign o_central_dma_en = q_r.cdma;
    assign o_host_clk_stop_ok = q_r.host_ok;
    assign o_card_clk_stop_ok = q_r.card_ok;
    assign o_wake_out = q_r.wake;
    assign o_mft6_out = q_r.mft6_out;
    assign o_mft6_oe = q_r.mft6_oe;
    assign o_route_low = q_r.route[23:0];

    default clocking cb_main @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    a_stream_start: assert property (
        (q_r.pw == PW_IDLE && i_pwr_req) |=> stat_stream)
        else $error("stream flag not set on power request");
    a_stream_len: assert property (
        $rose(stat_stream) |-> ##16 stat_stream ##1 !stat_stream)
        else $error("stream flag length wrong");
    a_up_settle: assert property (
        $fell(stat_up) |-> q_r.settle_len == 16'(SETTLE_UP_CYC))
        else $error("power-up settling length wrong");
    a_dn_settle: assert property (
        $rose(stat_dn) |-> stat_dn[*8] ##[1:300] !stat_dn)
        else $error("power-down settling not ended in time");
    a_probe_set: assert property (
        i_probe_start |=> rd_sys[BIT_PROBE])
        else $error("probe flag not set");
    a_rsvd_zero: assert property (
        !rd_sys[7] && !rd_sys[2] && rd_route[31:28] == 4'h0)
        else $error("reserved bits read nonzero");
    a_gate_idle: assert property (
        (q_r.ctl[BIT_GATE] && i_card_present && i_card_idle &&
        i_card_clk_stopped) |=> !o_cb_sm_clk_en)
        else $error("idle card clock not gated");
    a_parity_off: assert property (
        (i_card_parity_err && !q_r.ctl[BIT_PAR]) |=> !o_syserr)
        else $error("parity reported while disabled");
    a_keep_clock: assert property (
        q_r.ctl[BIT_KEEP] |=> !o_host_clk_stop_ok && !o_card_clk_stop_ok)
        else $error("clock stop allowed while inhibited");
    a_ring_first: assert property (
        (!q_r.ctl[BIT_SHARE] && i_ring_en) |=> o_wake_out == $past(i_ring_ind))
        else $error("ring indicate lost precedence");
    a_pme_only: assert property (
        (q_r.ctl[BIT_SHARE] && !i_pme_en) |=> !o_wake_out)
        else $error("ring indicate on wake pin when excluded");

endmodule // scr_top
`default_nettype wire

// *** tb/scr_psw_model.sv ***
// Purpose: Power switch model that captures the serial stream
// Assumes: Data stable at rising switch clock, MSB first
// Notes:   Word shows after the latch pulse
`timescale 1ns/10ps
`default_nettype none
module scr_psw_model
(
    // Switch pins
    input wire logic i_clk,
    input wire logic i_sw_clk,
    input wire logic i_sw_data,
    input wire logic i_sw_latch,
    // Latched word
    output logic [7:0] o_word
);
    logic [7:0] sh_r;
    logic clk_d_r = 1'h0;
    always_ff @(posedge i_clk)
    begin
        clk_d_r <= i_sw_clk;
        if (i_sw_clk && !clk_d_r)
            sh_r <= {sh_r[6:0], i_sw_data};
        if (i_sw_latch)
            o_word <= sh_r;
    end
endmodule // scr_psw_model
`default_nettype wire

// *** tb/scr_top_bench.sv ***
// Purpose: Self-checking bench for the register bank
// Assumes: EEPROM absent until the second reset; side inputs fixed except i_pme_en and i_ring_ind, changed once
// Notes:   Settling waits use the package cycle counts
`timescale 1ns/10ps
`default_nettype none
module scr_top_bench
    import scr_pkg::*;
;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0] r;
    } scr_row_s;
    logic i_clk, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic o_sw_clk, o_sw_data, o_sw_latch, o_cb_sm_clk_en, o_syserr;
    logic o_id_regs_write_lock, o_central_dma_en, o_host_clk_stop_ok;
    logic o_card_clk_stop_ok, o_wake_out, o_mft6_out, o_mft6_oe;
    logic o_ee_clk, o_ee_cs;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata;
    logic [23:0] o_route_low;
    logic [7:0] sw_word, w;
    logic i_rst_b = 1'h0, i_awvalid = 1'h0, i_wvalid = 1'h0;
    logic i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
    logic i_pwr_req = 1'h0, i_pwr_up = 1'h0, i_probe_start = 1'h0;
    logic i_probe_done = 1'h0, i_ee_present = 1'h0, i_ee_data = 1'h1;
    logic i_ring_ind = 1'h0, i_card_present = 1'h1, i_card_idle = 1'h1;
    logic i_card_clk_stopped = 1'h1, i_card_parity_err = 1'h1;
    logic i_host_clk_stop_req = 1'h1, i_card_clk_stop_req = 1'h1;
    logic i_ring_en = 1'h1, i_pme = 1'h1, i_pme_en = 1'h1;
    logic i_clkrun_drive = 1'h1;
    logic [7:0] i_awaddr = 8'h0, i_araddr = 8'h0, i_pwr_code = 8'h0;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0] i_wstrb = 4'hf;
    logic [15:0] i_isa_irq = 16'h5a3c;
    int n_mismatch = 0, samples_checked = 0;
    scr_row_s rows [3] = '{
        '{ADDR_SYSCTL, 32'hffffffff, 32'h0000007b, 2'h0},
        '{ADDR_ROUTE, 32'hffffffff, 32'h0fffffff, 2'h0},
        '{8'h40, 32'hffffffff, 32'h00000000, 2'h2}};

    scr_top i_dut (.*);
    scr_psw_model i_psw (
        .i_clk(i_clk),
        .i_sw_clk(o_sw_clk),
        .i_sw_data(o_sw_data),
        .i_sw_latch(o_sw_latch),
        .o_word(sw_word)
    );

    task automatic chk(input string nm, input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Both channels offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'h1;
        i_wvalid <= 1'h1;
        i_bready <= 1'h1;
        do
        begin
            @(posedge i_clk);
            if (o_awready) i_awvalid <= 1'h0;
            if (o_wready) i_wvalid <= 1'h0;
        end
        while (!o_bvalid);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] r);
        i_araddr <= a;
        i_arvalid <= 1'h1;
        i_rready <= 1'h1;
        do
        begin
            @(posedge i_clk);
            if (o_arready) i_arvalid <= 1'h0;
        end
        while (!o_rvalid);
        chk("rdata", o_rdata, e);
        chk("rresp", {30'h0, o_rresp}, {30'h0, r});
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        i_clk = 1'h0;
        forever #50 i_clk = ~i_clk;
    end

    // Cut a hang well past the EEPROM load
    initial
    begin
        repeat (9000) @(posedge i_clk);
        n_mismatch++;
        conclude();
    end

    initial
    begin
        repeat (10) @(posedge i_clk);
        i_rst_b <= 1'h1;
        rd(ADDR_SYSCTL, SYSCTL_RESET, 2'h0);
        rd(ADDR_ROUTE, ROUTE_RESET, 2'h0);
        chk("lock", o_id_regs_write_lock, 1);
        chk("mft6_oe", o_mft6_oe, 0);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            chk("bresp", {30'h0, o_bresp}, {30'h0, rows[i].r});
            rd(rows[i].a, rows[i].e, rows[i].r);
        end
        wr(ADDR_ROUTE, 32'h00200000);
        for (int s = 0; s < 2; s++)
        begin
            wr(ADDR_SYSCTL, s ? 32'h5b : 32'h0);
            repeat (2) @(posedge i_clk);
            chk("syserr", o_syserr, s);
            chk("cdma", o_central_dma_en, s);
            chk("stop", {o_host_clk_stop_ok, o_card_clk_stop_ok},
                3 - 3 * s);
            chk("gate", o_cb_sm_clk_en, 1 - s);
            chk("wake", o_wake_out, s);
        end
        i_pme_en <= 1'h0;
        i_ring_ind <= 1'h1;
        repeat (2) @(posedge i_clk);
        chk("wake", o_wake_out, 0);
        i_probe_start <= 1'h1;
        @(posedge i_clk);
        i_probe_start <= 1'h0;
        rd(ADDR_SYSCTL, 32'h15b, 2'h0);
        i_probe_done <= 1'h1;
        @(posedge i_clk);
        i_probe_done <= 1'h0;
        rd(ADDR_SYSCTL, 32'h5b, 2'h0);
        for (int u = 1; u >= 0; u--)
        begin
            w = u ? 8'ha6 : 8'h3c;
            i_pwr_code <= w;
            i_pwr_up <= u[0];
            i_pwr_req <= 1'h1;
            @(posedge i_clk);
            i_pwr_req <= 1'h0;
            rd(ADDR_SYSCTL, 32'h85b, 2'h0);
            do @(posedge i_clk); while (!o_sw_latch);
            @(posedge i_clk);
            chk("sw_word", sw_word, w);
            rd(ADDR_SYSCTL, u ? 32'h45b : 32'h25b, 2'h0);
            repeat ((u ? SETTLE_UP_CYC : SETTLE_DN_CYC) + 2) @(posedge i_clk);
            rd(ADDR_SYSCTL, 32'h5b, 2'h0);
        end
        for (int c = 0; c < 16; c++)
        begin
            wr(ADDR_ROUTE, c << T6_LSB);
            repeat (2) @(posedge i_clk);
            chk("mft6_oe", o_mft6_oe, c != 0);
            chk("mft6_out", o_mft6_out, c > 1 && i_isa_irq[c]);
        end
        i_ee_present <= 1'h1;
        i_rst_b <= 1'h0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'h1;
        repeat (2) @(posedge i_clk);
        chk("ee_cs", o_ee_cs, 1);
        repeat (60) @(posedge i_clk);
        chk("ee_clk", o_ee_clk, 1);
        rd(ADDR_ROUTE, ROUTE_RESET, 2'h0);
        repeat (EE_BITS * EE_HALF_CYC * 2) @(posedge i_clk);
        rd(ADDR_ROUTE, ROUTE_WR_MASK, 2'h0);
        conclude();
    end
endmodule // scr_top_bench
`default_nettype wire
